// File: rtl/timer_one_pkg.sv
// Operation
// - The timer advances only while the run bit is set; clearing it holds the count.
// - With run and gate enable set, counting follows the gate; gate disabled counts freely.
// - The two-bit prescale field divides input ticks by 1, 2, 4 or 8.
// - Low-power oscillator bit acts only when internal oscillator runs without clock output.
// - Source bit picks external rising edges or internal clock; sync bit matters only externally.
package timer_one_pkg;

    // ****************************************************************
    // Register bus geometry
    // ****************************************************************
    localparam int          ADDR_W         = 4;
    localparam int          DATA_W         = 8;
    localparam logic [3:0]  CONTROL_OFFSET = 4'h0;
    localparam logic [3:0]  STATUS_OFFSET  = 4'h1;

    // ****************************************************************
    // Control register fields
    // ****************************************************************
    localparam int          RUN_BIT        = 0;
    localparam int          SOURCE_BIT     = 1;
    localparam int          SYNC_N_BIT     = 2;
    localparam int          LP_OSC_BIT     = 3;
    localparam int          PRESCALE_LSB   = 4;
    localparam int          PRESCALE_W     = 2;
    localparam int          GATE_EN_BIT    = 6;
    localparam int          GATE_INV_BIT   = 7;
    localparam logic [7:0]  CONTROL_RESET  = 8'h00;

    // ****************************************************************
    // Status register fields
    // ****************************************************************
    localparam int          ST_EXT_BIT     = 0;
    localparam int          ST_GATE_BIT    = 1;
    localparam int          ST_ENABLE_BIT  = 2;
    localparam int          ST_LP_BIT      = 3;
    localparam int          ST_PRE_LSB     = 4;
    localparam int          PRE_CNT_W      = 3;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int          INT_CLK_DIV    = 4;
    localparam int          SYNC_STAGES    = 3;

    typedef enum logic [1:0] {
        DIV1 = 2'b00,
        DIV2 = 2'b01,
        DIV4 = 2'b10,
        DIV8 = 2'b11
    } prescale_t;

endpackage

// File: rtl/pin_sync.sv
`timescale 1ns/1ps
// Three-stage synchroniser; the first stage is seen only by the second.
module pin_sync (
    input  wire logic clk_i,
    input  wire logic reset_i,
    input  wire logic ce_i,
    input  wire logic pin_i,
    output logic      mid_o,
    output logic      last_o
);
    logic first_reg;

    // Shift the pin through three flops so metastability settles twice.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            first_reg <= 1'b0;
            mid_o     <= 1'b0;
            last_o    <= 1'b0;
        end else if (ce_i) begin
            first_reg <= pin_i;
            mid_o     <= first_reg;
            last_o    <= mid_o;
        end
    end
endmodule

// File: rtl/tick_prescaler.sv
`timescale 1ns/1ps
// Divides a stream of input ticks by 1, 2, 4 or 8.
module tick_prescaler
    import timer_one_pkg::*;
#(
    parameter int CNT_W = 3
) (
    input  wire logic                  clk_i,
    input  wire logic                  reset_i,
    input  wire logic                  ce_i,
    input  wire logic                  clear_i,
    input  wire logic                  tick_i,
    input  wire timer_one_pkg::prescale_t select_i,
    output logic                       tick_o,
    output logic [CNT_W-1:0]           count_o
);
    logic [CNT_W-1:0] limit;

    // Terminal count is one less than the ratio.
    always_comb begin
        unique case (select_i)
            DIV1: limit = CNT_W'(0);
            DIV2: limit = CNT_W'(1);
            DIV4: limit = CNT_W'(3);
            DIV8: limit = CNT_W'(7);
        endcase
    end

    // A register write restarts the division so a new ratio starts clean.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            count_o <= '0;
            tick_o  <= 1'b0;
        end else if (ce_i) begin
            tick_o <= 1'b0;
            if (clear_i) begin
                count_o <= '0;
            end else if (tick_i) begin
                if (count_o >= limit) begin
                    count_o <= '0;
                    tick_o  <= 1'b1;
                end else begin
                    count_o <= count_o + CNT_W'(1);
                end
            end
        end
    end
endmodule

// File: rtl/timer_one_control.sv
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module timer_one_control (
    input  wire logic                          clk_i,
    input  wire logic                          reset_i,
    input  wire logic                          ce_i,
    input  wire logic [timer_one_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [timer_one_pkg::DATA_W-1:0] wdata_i,
    input  wire logic                          write_i,
    input  wire logic                          read_i,
    output logic [timer_one_pkg::DATA_W-1:0]   rdata_o,
    input  wire logic                          ext_clock_pin_i,
    input  wire logic                          gate_input_pin_i,
    input  wire logic                          second_comparator_output_i,
    input  wire logic                          gate_source_select_i,
    input  wire logic                          internal_oscillator_no_clock_output_pin_i,
    output logic                               low_power_osc_on_o,
    output logic                               count_tick_o
);
    import timer_one_pkg::*;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    localparam int DIV_W = $clog2(INT_CLK_DIV);

    logic [DATA_W-1:0]    control_reg;
    logic [DIV_W-1:0]     int_div_reg;
    logic                 ext_level_reg;
    logic                 gate_level_reg;
    logic                 comp_level_reg;
    logic                 pending_reg;
    logic                 ext_mid;
    logic                 ext_last;
    logic                 gate_mid;
    logic                 gate_last;
    logic                 comp_mid;
    logic                 comp_last;
    logic                 control_write;
    logic                 int_tick;
    logic                 ext_edge;
    logic                 ext_tick;
    logic                 src_tick;
    logic                 gate_raw;
    logic                 gate_allow;
    logic                 count_enable;
    logic                 prescale_in;
    logic [PRE_CNT_W-1:0] pre_count;
    prescale_t            prescale_sel;

    logic run;
    logic source_ext;
    logic sync_n;
    logic gate_en;
    logic gate_inv;

    assign run          = control_reg[RUN_BIT];
    assign source_ext   = control_reg[SOURCE_BIT];
    assign sync_n       = control_reg[SYNC_N_BIT];
    assign gate_en      = control_reg[GATE_EN_BIT];
    assign gate_inv     = control_reg[GATE_INV_BIT];
    assign prescale_sel = prescale_t'(control_reg[PRESCALE_LSB +: PRESCALE_W]);

    // ****************************************************************
    // Register port
    // ****************************************************************

    // Only the control register is writable; status writes are dropped.
    assign control_write = write_i && (addr_i == CONTROL_OFFSET);

    // Control register, all bits cleared at reset.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            control_reg <= CONTROL_RESET;
        end else if (ce_i && control_write) begin
            control_reg <= wdata_i;
        end
    end

    // Read data appear in the cycle after the strobe and only there.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rdata_o <= '0;
        end else if (ce_i) begin
            rdata_o <= '0;
            if (read_i) begin
                unique case (addr_i)
                    CONTROL_OFFSET: rdata_o <= control_reg;
                    STATUS_OFFSET: begin
                        rdata_o[ST_EXT_BIT]                  <= ext_level_reg;
                        rdata_o[ST_GATE_BIT]                 <= gate_raw;
                        rdata_o[ST_ENABLE_BIT]               <= count_enable;
                        rdata_o[ST_LP_BIT]                   <= low_power_osc_on_o;
                        rdata_o[ST_PRE_LSB +: PRE_CNT_W]     <= pre_count;
                    end
                    default: rdata_o <= '0; // Unmapped offsets read as zero.
                endcase
            end
        end
    end

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    pin_sync ext_sync (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .ce_i    (ce_i),
        .pin_i   (ext_clock_pin_i),
        .mid_o   (ext_mid),
        .last_o  (ext_last)
    );

    pin_sync gate_sync (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .ce_i    (ce_i),
        .pin_i   (gate_input_pin_i),
        .mid_o   (gate_mid),
        .last_o  (gate_last)
    );

    pin_sync comp_sync (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .ce_i    (ce_i),
        .pin_i   (second_comparator_output_i),
        .mid_o   (comp_mid),
        .last_o  (comp_last)
    );

    // A level is accepted only once two later stages agree, filtering glitches.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ext_level_reg  <= 1'b0;
            gate_level_reg <= 1'b0;
            comp_level_reg <= 1'b0;
        end else if (ce_i) begin
            if (ext_mid == ext_last) begin
                ext_level_reg <= ext_last;
            end
            if (gate_mid == gate_last) begin
                gate_level_reg <= gate_last;
            end
            if (comp_mid == comp_last) begin
                comp_level_reg <= comp_last;
            end
        end
    end

    // ****************************************************************
    // Clock sources
    // ****************************************************************

    // The internal timer clock is the instruction rate, a fixed fraction of clk_i.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            int_div_reg <= '0;
        end else if (ce_i) begin
            if (int_div_reg == DIV_W'(INT_CLK_DIV - 1)) begin
                int_div_reg <= '0;
            end else begin
                int_div_reg <= int_div_reg + DIV_W'(1);
            end
        end
    end

    assign int_tick = (int_div_reg == DIV_W'(INT_CLK_DIV - 1));

    // Rising edge of the filtered external level.
    assign ext_edge = ext_last && (ext_mid == ext_last) && !ext_level_reg;

    // In synchronised mode an edge waits for the next internal tick; a new edge
    // in the consuming cycle is merged rather than lost.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pending_reg <= 1'b0;
        end else if (ce_i) begin
            if (ext_edge && !int_tick) begin
                pending_reg <= 1'b1;
            end else if (int_tick) begin
                pending_reg <= 1'b0;
            end
        end
    end

    // Unsynchronised mode passes each edge at once; it cannot line up with
    // the internal clock, which is why compare users prefer the other mode.
    assign ext_tick = sync_n ? ext_edge : (int_tick && (pending_reg || ext_edge));
    assign src_tick = source_ext ? ext_tick : int_tick;

    // ****************************************************************
    // Gate and run control
    // ****************************************************************
    assign gate_raw     = gate_source_select_i ? comp_level_reg : gate_level_reg;
    assign gate_allow   = gate_inv ? gate_raw : !gate_raw;
    assign count_enable = run && (!gate_en || gate_allow);
    assign prescale_in  = src_tick && count_enable;

    tick_prescaler #(
        .CNT_W (PRE_CNT_W)
    ) prescaler (
        .clk_i    (clk_i),
        .reset_i  (reset_i),
        .ce_i     (ce_i),
        .clear_i  (control_write),
        .tick_i   (prescale_in),
        .select_i (prescale_sel),
        .tick_o   (count_tick_o),
        .count_o  (pre_count)
    );

    // ****************************************************************
    // Low-power oscillator
    // ****************************************************************

    // The enable bit only takes effect in the matching oscillator setup.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            low_power_osc_on_o <= 1'b0;
        end else if (ce_i) begin
            low_power_osc_on_o <= control_reg[LP_OSC_BIT] && internal_oscillator_no_clock_output_pin_i;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    stop_holds_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        (ce_i && !run) |=> !count_tick_o
    ) else $error("Timer ticked while stopped.");

    // Watched at the output, so a wrong enable term cannot hide behind itself.
    free_count_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        (ce_i && run && !gate_en && !source_ext && int_tick && prescale_sel == DIV1
            && !control_write) |=> count_tick_o
    ) else $error("Ungated running timer dropped a tick.");

    gate_block_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        (ce_i && gate_en && !gate_allow) |=> !count_tick_o
    ) else $error("Timer ticked while gate closed.");

    gate_polarity_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        (ce_i && gate_en && (gate_inv != gate_raw)) |=> !count_tick_o
    ) else $error("Gate polarity not honoured.");

    div_one_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        (ce_i && prescale_sel == DIV1 && prescale_in && !control_write) |=> count_tick_o
    ) else $error("Divide by one missed a tick.");

    div_eight_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        (ce_i && $rose(count_tick_o) && prescale_sel == DIV8 && !$past(control_write))
            |-> ($past(pre_count) == 3'h7)
    ) else $error("Divide by eight ticked early.");

    lp_osc_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        (ce_i && !internal_oscillator_no_clock_output_pin_i) |=> !low_power_osc_on_o
    ) else $error("Low-power oscillator enabled in wrong configuration.");

    int_source_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        (ce_i && !source_ext && !int_tick) |=> !count_tick_o
    ) else $error("Internal source not used.");

    ext_synced_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        (ce_i && source_ext && !sync_n && !int_tick) |=> !count_tick_o
    ) else $error("Synchronised external tick off the internal clock.");

    // A stopped timer holds its prescale count still; the control write that restarts it clears the count.
    count_hold_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        (ce_i && !run && !control_write) |=> $stable(pre_count)
    ) else $error("Prescale count moved while stopped.");

    // A synchronised edge between internal ticks must wait, not vanish.
    edge_held_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        (ce_i && ext_edge && !int_tick) |=> pending_reg
    ) else $error("External edge lost before the internal tick.");

    // Unsynchronised edges skip the wait for the internal tick.
    unsync_pass_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        (ce_i && source_ext && sync_n && ext_edge && count_enable && prescale_sel == DIV1
            && !control_write) |=> count_tick_o
    ) else $error("Unsynchronised external edge not passed on.");

    // Every second enabled source tick reaches the counter.
    div_two_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        (ce_i && $rose(count_tick_o) && prescale_sel == DIV2 && !$past(control_write))
            |-> ($past(pre_count) == 3'h1)
    ) else $error("Divide by two ticked early.");

    // In the matching oscillator setup the output follows the enable bit.
    lp_follow_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        (ce_i && internal_oscillator_no_clock_output_pin_i)
            |=> (low_power_osc_on_o == $past(control_reg[LP_OSC_BIT]))
    ) else $error("Low-power oscillator ignored its enable bit.");

endmodule

// File: bench/pin_source.sv
`timescale 1ns/1ps
// ****************************************************************
// Far-side sources for the external clock pin and both gate inputs
// ****************************************************************
module pin_source (
    input  wire logic clk_i,
    input  wire logic ext_run_i,
    input  wire logic gate_level_i,
    output logic      ext_clock_pin_o,
    output logic      gate_input_pin_o,
    output logic      second_comparator_output_o
);
    logic [1:0] phase_reg;

    // The external clock toggles every four system clocks while enabled, a period of
    // eight clocks; otherwise it stands low so that a stray edge cannot be counted.
    always_ff @(posedge clk_i) begin
        if (ext_run_i) begin
            phase_reg <= phase_reg + 2'h1;
            if (phase_reg == 2'h3) begin
                ext_clock_pin_o <= ~ext_clock_pin_o;
            end
        end else begin
            phase_reg       <= 2'h0;
            ext_clock_pin_o <= 1'b0;
        end
    end

    // The comparator carries the opposite level, so a wrong gate source choice shows.
    assign gate_input_pin_o           = gate_level_i;
    assign second_comparator_output_o = ~gate_level_i;
endmodule

// File: bench/timer1_control_settings_bench.sv
`timescale 1ns/1ps
module timer1_control_settings_bench;
    import timer_one_pkg::*;

    // ****************************************************************
    // Signals
    // ****************************************************************
    logic        clk_i      = 1'b0;
    logic        reset_i    = 1'b1;
    logic [3:0]  addr_i     = 4'h0;
    logic [7:0]  wdata_i    = 8'h00;
    logic        write_i    = 1'b0;
    logic        read_i     = 1'b0;
    logic [7:0]  rdata_o;
    logic        ext_pin;
    logic        gate_pin;
    logic        cmp_out;
    logic        gate_source_select_i = 1'b0;
    logic        osc_cfg    = 1'b0;
    logic        lp_on;
    logic        count_tick_o;
    logic        ext_run    = 1'b0;
    logic        gate_level = 1'b0;
    int          n_errors   = 0;
    int          checked    = 0;

    // The clock runs at 100 MHz.
    always #5 clk_i = ~clk_i;

    timer_one_control timer_one_control_i (
        .clk_i                           (clk_i),
        .reset_i                         (reset_i),
        .ce_i                            (1'b1),
        .addr_i                          (addr_i),
        .wdata_i                         (wdata_i),
        .write_i                         (write_i),
        .read_i                          (read_i),
        .rdata_o                         (rdata_o),
        .ext_clock_pin_i                 (ext_pin),
        .gate_input_pin_i                (gate_pin),
        .second_comparator_output_i      (cmp_out),
        .gate_source_select_i            (gate_source_select_i),
        .internal_oscillator_no_clock_output_pin_i (osc_cfg),
        .low_power_osc_on_o              (lp_on),
        .count_tick_o                    (count_tick_o)
    );

    pin_source pin_source_i (
        .clk_i                      (clk_i),
        .ext_run_i                  (ext_run),
        .gate_level_i               (gate_level),
        .ext_clock_pin_o            (ext_pin),
        .gate_input_pin_o           (gate_pin),
        .second_comparator_output_o (cmp_out)
    );

    // ****************************************************************
    // Tasks
    // ****************************************************************
    // Comparisons go through one place so every mismatch is counted the same way.
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        if (n_errors == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic write_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        write_i <= 1'b1;
        @(posedge clk_i);
        write_i <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so they are sampled there.
    task automatic read_reg(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        addr_i <= a;
        read_i <= 1'b1;
        @(posedge clk_i);
        read_i <= 1'b0;
        #1;
        check(rdata_o, exp);
    endtask

    // A window of 64 clocks holds a whole number of every tick period used here,
    // so the count does not depend on the phase at which the window opens.
    task automatic cfg(input logic [7:0] d, input logic [7:0] exp);
        logic [7:0] n;
        n = 8'h00;
        write_reg(CONTROL_OFFSET, d);
        repeat (40) @(posedge clk_i);
        repeat (64) begin
            @(posedge clk_i);
            #1;
            if (count_tick_o === 1'b1) begin
                n = n + 8'h01;
            end
        end
        check(n, exp);
        // Return on an edge so that the next stimulus changes there too.
        @(posedge clk_i);
    endtask

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        repeat (6) @(posedge clk_i);
        reset_i <= 1'b0;
        read_reg(CONTROL_OFFSET, CONTROL_RESET);
        read_reg(4'hf, 8'h00);
        write_reg(CONTROL_OFFSET, 8'ha5);
        read_reg(CONTROL_OFFSET, 8'ha5);
        // The status offset is read only, so a write there must not reach control.
        write_reg(STATUS_OFFSET, 8'hff);
        read_reg(CONTROL_OFFSET, 8'ha5);
        cfg(8'h00, 8'h00);
        // Internal clock is a tick every four clocks before the prescaler.
        for (int i = 0; i < 4; i++) begin
            cfg({2'b00, 2'(i), 4'h1}, 8'(16 >> i));
        end
        cfg(8'h30, 8'h00);
        // Gate enable is set in the same write that relies on the gate source.
        for (int i = 0; i < 8; i++) begin
            gate_source_select_i <= i[0];
            gate_level           <= i[1];
            cfg({i[2], 1'b1, 6'h01}, ((i[0] ^ i[1]) == i[2]) ? 8'h10 : 8'h00);
        end
        cfg(8'h01, 8'h10);
        cfg(8'h05, 8'h10);
        cfg(8'h43, 8'h00);
        ext_run <= 1'b1;
        cfg(8'h01, 8'h10);
        cfg(8'h07, 8'h08);
        cfg(8'h03, 8'h08);
        cfg(8'h37, 8'h01);
        // A reset in mid-run must stop the timer and clear the control register.
        reset_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        read_reg(CONTROL_OFFSET, CONTROL_RESET);
        check({7'h00, count_tick_o}, 8'h00);
        // Quiet pins make the status word predictable: gate from comparator, high.
        ext_run    <= 1'b0;
        gate_level <= 1'b0;
        osc_cfg    <= 1'b1;
        write_reg(CONTROL_OFFSET, 8'h08);
        repeat (3) @(posedge clk_i);
        check({7'h00, lp_on}, 8'h01);
        read_reg(STATUS_OFFSET, 8'h0a);
        osc_cfg <= 1'b0;
        repeat (3) @(posedge clk_i);
        check({7'h00, lp_on}, 8'h00);
        osc_cfg <= 1'b1;
        write_reg(CONTROL_OFFSET, 8'h00);
        repeat (3) @(posedge clk_i);
        check({7'h00, lp_on}, 8'h00);
        print_verdict();
    end

    // The tests need about 2,300 clocks; a hang is cut at about thirteen times that.
    initial begin
        #300000;
        n_errors = n_errors + 1;
        print_verdict();
    end
endmodule
